// ### hw/segment_lcd_serial_input.v
// How it works
// RL1: one data bit per shift clock rise
// RL2: stored one lights segment, zero not
// RL3: bits accepted only while select low
// RL4: select falling edge clears bit counter
// RL5: flag at eighth edge picks command/data
// RL6: reset pin low clears address, display off
// RL7: words are whole eight-bit units
// RL8: display memory holds 128 bits
// RL9: four commons scanned at quarter duty
// RL10: thirty-two segment outputs follow memory
// RL11: external clock from osc pin, feedback open
// RL12: link inputs synchronised before use
// RL13: serial words arrive MSB first
// RL14: address steps two per byte, one per rewrite
// RL15: byte upper nibble at addr, lower next
// RL16: reset command: display off, address cleared
`include "segment_lcd_consts.vh"

module segment_lcd_serial_input #(
  parameter OSC_DIV         = `LCD_OSC_DIV,
  parameter TICKS_PER_PHASE = `LCD_TICKS_PER_PHASE,
  parameter FIFO_DEPTH      = `LCD_FIFO_DEPTH
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        sck_i,
  input  wire        serial_data_in_i,
  input  wire        cs_n_i,
  input  wire        cmd_data_i,
  input  wire        lcd_reset_n_i,
  input  wire        osc_clock_in_i,
  input  wire        osc_ext_sel_i,
  output wire        osc_feedback_out_o,
  output reg  [3:0]  common_drive_outputs_o,
  output reg  [31:0] segment_drive_outputs_o,
  output reg  [1:0]  display_mode_o,
  output reg  [4:0]  address_o,
  output reg         overrun_o
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_LOWER = 1'b1;

  // Address step with natural wrap from 1F to 00
  function [4:0] addr_step;
    input [4:0] addr;
    input [4:0] step;
    begin
      addr_step = addr + step;
    end
  endfunction

  // RL12: two-stage synchronisers
  reg  [1:0] sck_sync_ff;
  reg  [1:0] sd_sync_ff;
  reg  [1:0] cs_sync_ff;
  reg  [1:0] cd_sync_ff;
  reg  [1:0] rstn_sync_ff;
  reg  [1:0] osc_sync_ff;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sck_sync_ff  <= 2'h0;
      sd_sync_ff   <= 2'h0;
      cs_sync_ff   <= 2'h3;
      cd_sync_ff   <= 2'h0;
      rstn_sync_ff <= 2'h3;
      osc_sync_ff  <= 2'h0;
    end else begin
      sck_sync_ff  <= {sck_sync_ff[0], sck_i};
      sd_sync_ff   <= {sd_sync_ff[0], serial_data_in_i};
      cs_sync_ff   <= {cs_sync_ff[0], cs_n_i};
      cd_sync_ff   <= {cd_sync_ff[0], cmd_data_i};
      rstn_sync_ff <= {rstn_sync_ff[0], lcd_reset_n_i};
      osc_sync_ff  <= {osc_sync_ff[0], osc_clock_in_i};
    end
  end

  // Delayed copies for edge finding, only second stages are looked at
  reg sck_prev_ff;
  reg cs_prev_ff;
  reg osc_prev_ff;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sck_prev_ff <= 1'b0;
      cs_prev_ff  <= 1'b1;
      osc_prev_ff <= 1'b0;
    end else begin
      sck_prev_ff <= sck_sync_ff[1];
      cs_prev_ff  <= cs_sync_ff[1];
      osc_prev_ff <= osc_sync_ff[1];
    end
  end

  wire sck_rise = sck_sync_ff[1] & ~sck_prev_ff;
  wire cs_fall  = ~cs_sync_ff[1] & cs_prev_ff;
  wire cs_low   = ~cs_sync_ff[1];
  wire pin_rst  = ~rstn_sync_ff[1];

  // Serial shift register and bit counter
  reg  [2:0] bit_cnt_ff;
  reg  [6:0] shift_ff;
  wire       word_done;
  wire [8:0] word_data;
  wire       fifo_wr_ready;

  // RL5: flag sampled with the eighth bit
  assign word_done = cs_low & sck_rise & (bit_cnt_ff == 3'h7);
  assign word_data = {cd_sync_ff[1], shift_ff, sd_sync_ff[1]};

  always @(posedge ref_clk_i) begin
    if (rst_i || pin_rst) begin
      bit_cnt_ff <= 3'h0;
      shift_ff   <= 7'h00;
    // RL4: new frame restarts count
    end else if (cs_fall) begin
      bit_cnt_ff <= 3'h0;
    // RL3: ignore clocks while deselected
    end else if (cs_low && sck_rise) begin
      // RL1: one bit per rise
      // RL7: counter wraps every eight bits
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      // RL13: shift MSB first
      shift_ff   <= {shift_ff[5:0], sd_sync_ff[1]};
    end
  end

  // Serial link cannot stall, so a full buffer drops the word and flags it
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      overrun_o <= 1'b0;
    end else begin
      overrun_o <= word_done & ~fifo_wr_ready & ~pin_rst;
    end
  end

  wire       fifo_rd_valid;
  wire       fifo_rd_ready;
  wire [8:0] fifo_rd_data;

  lcd_word_fifo #(
    .WIDTH (`LCD_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .wr_valid_i (word_done & ~pin_rst),
    .wr_ready_o (fifo_wr_ready),
    .wr_data_i  (word_data),
    .rd_valid_o (fifo_rd_valid),
    .rd_ready_i (fifo_rd_ready),
    .rd_data_o  (fifo_rd_data)
  );

  // RL8: 32 by 4 bits of display memory
  reg  [3:0] display_memory_ff [0:31];
  reg        state_ff;
  reg  [3:0] low_nib_ff;
  reg        nxt_state;
  reg  [4:0] nxt_addr;
  reg  [1:0] nxt_mode;
  reg        wr_en;
  reg  [3:0] wr_data;

  wire [2:0] opcode = fifo_rd_data[7:5];
  wire       is_cmd = fifo_rd_data[`LCD_FIFO_CMD_BIT];

  // Executor stalls on the lower nibble and while reset pin held
  assign fifo_rd_ready = (state_ff == ST_IDLE) & ~pin_rst;

  // Command and data execution
  always @* begin
    nxt_state = state_ff;
    nxt_addr  = address_o;
    nxt_mode  = display_mode_o;
    wr_en     = 1'b0;
    wr_data   = 4'h0;
    case (state_ff)
      ST_IDLE: begin
        if (fifo_rd_valid && fifo_rd_ready) begin
          if (!is_cmd) begin
            // RL15: upper nibble first
            wr_en     = 1'b1;
            wr_data   = fifo_rd_data[7:4];
            nxt_addr  = addr_step(address_o, `LCD_STEP_NIBBLE);
            nxt_state = ST_LOWER;
          end else begin
            case (opcode)
              `LCD_OP_ADDR_SET: begin
                nxt_addr = fifo_rd_data[4:0];
              end
              `LCD_OP_DISP_ON: begin
                nxt_mode = `LCD_MODE_ALL_ON;
              end
              `LCD_OP_DISP_OFF: begin
                nxt_mode = `LCD_MODE_OFF;
              end
              `LCD_OP_DISP_START: begin
                nxt_mode = `LCD_MODE_NORMAL;
              end
              `LCD_OP_REWRITE: begin
                // RL14: rewrite steps by one
                wr_en    = 1'b1;
                wr_data  = fifo_rd_data[3:0];
                nxt_addr = addr_step(address_o, `LCD_STEP_NIBBLE);
              end
              `LCD_OP_RESET: begin
                // RL16: command reset
                nxt_mode = `LCD_MODE_OFF;
                nxt_addr = `LCD_ADDR_RESET;
              end
              default: begin
                nxt_mode = display_mode_o;
              end
            endcase
          end
        end
      end
      ST_LOWER: begin
        // RL15: lower nibble at address plus one
        // RL14: total step of two per byte
        wr_en     = 1'b1;
        wr_data   = low_nib_ff;
        nxt_addr  = addr_step(address_o, `LCD_STEP_NIBBLE);
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Control state; the reset pin aborts a half-written byte
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_ff       <= ST_IDLE;
      address_o      <= `LCD_ADDR_RESET;
      display_mode_o <= `LCD_MODE_RESET;
      low_nib_ff     <= 4'h0;
    // RL6: pin reset initialises
    end else if (pin_rst) begin
      state_ff       <= ST_IDLE;
      address_o      <= `LCD_ADDR_RESET;
      display_mode_o <= `LCD_MODE_OFF;
    end else begin
      state_ff       <= nxt_state;
      address_o      <= nxt_addr;
      display_mode_o <= nxt_mode;
      if (state_ff == ST_IDLE) begin
        low_nib_ff <= fifo_rd_data[3:0];
      end
    end
  end

  // Display memory write port, cleared only by system reset
  integer i;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < `LCD_NUM_ADDR; i = i + 1) begin
        display_memory_ff[i] <= 4'h0;
      end
    end else if (wr_en && !pin_rst) begin
      display_memory_ff[address_o] <= wr_data;
    end
  end

  // RL11: timing tick from osc pin or internal divider
  reg  [15:0] osc_div_ff;
  reg         osc_tick;
  wire        int_tick = (osc_div_ff == (OSC_DIV[15:0] - 16'h0001));

  always @(posedge ref_clk_i) begin
    if (rst_i || int_tick) begin
      osc_div_ff <= 16'h0000;
    end else begin
      osc_div_ff <= osc_div_ff + 16'h0001;
    end
  end

  always @* begin
    if (osc_ext_sel_i) begin
      osc_tick = osc_sync_ff[1] & ~osc_prev_ff;
    end else begin
      osc_tick = int_tick;
    end
  end

  // Feedback pin not used with an external clock, held low
  assign osc_feedback_out_o = 1'b0;

  // RL9: common phase counter, quarter duty
  reg [7:0] phase_tick_ff;
  reg [1:0] com_idx_ff;
  wire      phase_end = osc_tick & (phase_tick_ff == (TICKS_PER_PHASE[7:0] - 8'h01));

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase_tick_ff <= 8'h00;
      com_idx_ff    <= 2'h0;
    end else if (phase_end) begin
      phase_tick_ff <= 8'h00;
      com_idx_ff    <= com_idx_ff + 2'h1;
    end else if (osc_tick) begin
      phase_tick_ff <= phase_tick_ff + 8'h01;
    end
  end

  // RL10: segment outputs per common phase
  // RL2: one lights, zero leaves unlit
  integer s;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      common_drive_outputs_o  <= 4'h0;
      segment_drive_outputs_o <= 32'h00000000;
    end else begin
      common_drive_outputs_o <= 4'h1 << com_idx_ff;
      for (s = 0; s < `LCD_NUM_SEGMENTS; s = s + 1) begin
        if (display_mode_o == `LCD_MODE_ALL_ON) begin
          segment_drive_outputs_o[s] <= 1'b1;
        end else if (display_mode_o == `LCD_MODE_NORMAL) begin
          segment_drive_outputs_o[s] <= display_memory_ff[s][com_idx_ff];
        end else begin
          segment_drive_outputs_o[s] <= 1'b0;
        end
      end
    end
  end

endmodule

// ### inc/segment_lcd_consts.vh
`ifndef SEGMENT_LCD_CONSTS_VH
`define SEGMENT_LCD_CONSTS_VH

// System clock and internal oscillator rates
`define LCD_CLK_HZ          50000000
`define LCD_OSC_HZ          36000
`define LCD_OSC_DIV         (`LCD_CLK_HZ / `LCD_OSC_HZ)

// Oscillator ticks spent on each common phase
`define LCD_TICKS_PER_PHASE 64

// Serial word layout
`define LCD_WORD_BITS       8
`define LCD_FIFO_WIDTH      9
`define LCD_FIFO_DEPTH      4
`define LCD_FIFO_CMD_BIT    8

// Display memory geometry
`define LCD_ADDR_BITS       5
`define LCD_NIBBLE_BITS     4
`define LCD_NUM_ADDR        32
`define LCD_NUM_COMMONS     4
`define LCD_NUM_SEGMENTS    32

// Address counter steps
`define LCD_STEP_BYTE       5'h02
`define LCD_STEP_NIBBLE     5'h01
`define LCD_ADDR_RESET      5'h00

// Command opcodes, top three bits of a command byte
`define LCD_OP_ADDR_SET     3'h0
`define LCD_OP_DISP_ON      3'h1
`define LCD_OP_DISP_OFF     3'h2
`define LCD_OP_DISP_START   3'h3
`define LCD_OP_REWRITE      3'h4
`define LCD_OP_RESET        3'h6

// Display modes
`define LCD_MODE_OFF        2'h0
`define LCD_MODE_ALL_ON     2'h1
`define LCD_MODE_NORMAL     2'h2
`define LCD_MODE_RESET      2'h0

`endif

// ### hw/lcd_word_fifo.v
// Small word buffer between the serial front end and the command executor
module lcd_word_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             ref_clk_i,
  input  wire             rst_i,
  input  wire             wr_valid_i,
  output wire             wr_ready_o,
  input  wire [WIDTH-1:0] wr_data_i,
  output wire             rd_valid_o,
  input  wire             rd_ready_i,
  output wire [WIDTH-1:0] rd_data_o
);

  reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg  [AW:0]      wr_ptr_ff;
  reg  [AW:0]      rd_ptr_ff;
  wire             full;
  wire             empty;
  wire             do_wr;
  wire             do_rd;

  // Extra pointer bit tells full from empty
  assign empty      = (wr_ptr_ff == rd_ptr_ff);
  assign full       = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                      (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign wr_ready_o = ~full;
  assign rd_valid_o = ~empty;
  assign do_wr      = wr_valid_i & ~full;
  assign do_rd      = rd_ready_i & ~empty;
  // Head word comes straight from the storage registers
  assign rd_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];

  // Storage, no reset needed since empty masks it
  always @(posedge ref_clk_i) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= wr_data_i;
    end
  end

  // Pointers
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ### testbench/segment_lcd_serial_input_chk.sv
module segment_lcd_serial_input_chk (
  input logic        ref_clk_i,
  input logic        rst_i,
  input logic        sck_i,
  input logic        cs_n_i,
  input logic        lcd_reset_n_i,
  input logic        osc_feedback_out_o,
  input logic [3:0]  common_drive_outputs_o,
  input logic [31:0] segment_drive_outputs_o,
  input logic [1:0]  display_mode_o,
  input logic [4:0]  address_o,
  input logic        overrun_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cs_idle_ff;
  logic [4:0] sck_idle_ff;
  // Quiet-link counters saturate so a long idle never wraps
  always @(posedge ref_clk_i) begin
    if (rst_i || !lcd_reset_n_i || !cs_n_i) cs_idle_ff <= 5'h00;
    else if (cs_idle_ff != 5'h1F) cs_idle_ff <= cs_idle_ff + 5'h01;
    if (rst_i || !lcd_reset_n_i || $changed(sck_i)) sck_idle_ff <= 5'h00;
    else if (sck_idle_ff != 5'h1F) sck_idle_ff <= sck_idle_ff + 5'h01;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_FEEDBACK_OPEN: assert property (osc_feedback_out_o == 1'b0)
    else $error("feedback output driven");
  AST_COMMON_ONEHOT: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    $onehot(common_drive_outputs_o)) else $error("commons not one-hot");
  AST_COMMON_ROTATE: assert property ($changed(common_drive_outputs_o) && !$past(rst_i)
    && !$past(rst_i, 2) |-> common_drive_outputs_o ==
    {$past(common_drive_outputs_o[2:0]), $past(common_drive_outputs_o[3])})
    else $error("commons out of order");
  AST_OFF_BLANK: assert property ((display_mode_o == 2'h0) [*2] |->
    segment_drive_outputs_o == 32'h00000000) else $error("segments lit while off");
  AST_ALL_ON: assert property ((display_mode_o == 2'h1) [*2] |->
    segment_drive_outputs_o == 32'hFFFFFFFF) else $error("segments dark while all on");
  AST_PIN_RESET: assert property (!lcd_reset_n_i [*5] |->
    address_o == 5'h00 && display_mode_o == 2'h0) else $error("pin reset not applied");
  AST_CS_HIGH_IGNORED: assert property (cs_idle_ff >= 5'h10 |->
    $stable(address_o) && $stable(display_mode_o)) else $error("word taken with select high");
  AST_SCK_STILL: assert property (sck_idle_ff >= 5'h10 |-> $stable(address_o))
    else $error("address moved without shift clock");
  AST_OVERRUN_PULSE: assert property (overrun_o |=> !overrun_o)
    else $error("overrun longer than a pulse");
endmodule

bind segment_lcd_serial_input segment_lcd_serial_input_chk segment_lcd_serial_input_chk_inst (
  .ref_clk_i              (ref_clk_i),
  .rst_i                  (rst_i),
  .sck_i                  (sck_i),
  .cs_n_i                 (cs_n_i),
  .lcd_reset_n_i          (lcd_reset_n_i),
  .osc_feedback_out_o     (osc_feedback_out_o),
  .common_drive_outputs_o (common_drive_outputs_o),
  .segment_drive_outputs_o(segment_drive_outputs_o),
  .display_mode_o         (display_mode_o),
  .address_o              (address_o),
  .overrun_o              (overrun_o)
);

// ### testbench/lcd_host_model.sv
module lcd_host_model (
  input  logic ref_clk_i,
  output logic sck_o,
  output logic sd_o,
  output logic cs_n_o,
  output logic cd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Link idles with select high and shift clock low
  initial begin
    sck_o = 1'b0;
    sd_o = 1'b0;
    cs_n_o = 1'b1;
    cd_o = 1'b0;
  end
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Sends n bits of v; sel low keeps select high to provoke a refusal
  task automatic send(input logic [7:0] v, input logic cd, input int n, input logic sel);
    @(negedge ref_clk_i);
    // select low for the whole word
    cs_n_o = !sel;
    // flag settled long before the eighth edge
    cd_o = cd;
    ticks(4);
    // MSB first, n clocks per word; data held 100 ns past rise
    for (int i = 7; i > 7 - n; i--) begin
      sck_o = 1'b0;
      ticks(1);
      sd_o = v[i];
      ticks(3);
      sck_o = 1'b1;
      ticks(4);
    end
    sck_o = 1'b0;
    ticks(4);
    // Released lines show a moving value, never a stale one
    sd_o = !sd_o;
    cs_n_o = 1'b1;
    cd_o = !cd;
    ticks(4);
  endtask
endmodule

// ### testbench/segment_lcd_serial_input_tb_top.sv
module segment_lcd_serial_input_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i;
  logic        rst_i;
  logic        sck_i;
  logic        serial_data_in_i;
  logic        cs_n_i;
  logic        cmd_data_i;
  logic        lcd_reset_n_i;
  logic        osc_clock_in_i;
  logic        osc_ext_sel_i;
  logic [3:0]  common_drive_outputs_o;
  logic [31:0] segment_drive_outputs_o;
  logic [1:0]  display_mode_o;
  logic [4:0]  address_o;
  logic        overrun_o;
  int          n_errors;
  int          checks_done;
  logic [3:0]  mem [32];
  logic [4:0]  ad;
  logic [1:0]  md;
  logic [31:0] r;
  int          n_overruns = 0;
  // Short display timing keeps each common phase a few cycles long
  // feedback output left open
  segment_lcd_serial_input #(.OSC_DIV(4), .TICKS_PER_PHASE(2), .FIFO_DEPTH(4))
    segment_lcd_serial_input_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck_i), .serial_data_in_i(serial_data_in_i),
    .cs_n_i(cs_n_i), .cmd_data_i(cmd_data_i), .lcd_reset_n_i(lcd_reset_n_i),
    .osc_clock_in_i(osc_clock_in_i), .osc_ext_sel_i(osc_ext_sel_i), .osc_feedback_out_o(),
    .common_drive_outputs_o(common_drive_outputs_o),
    .segment_drive_outputs_o(segment_drive_outputs_o), .display_mode_o(display_mode_o),
    .address_o(address_o), .overrun_o(overrun_o));
  lcd_host_model lcd_host_model_inst (.ref_clk_i(ref_clk_i), .sck_o(sck_i),
    .sd_o(serial_data_in_i), .cs_n_o(cs_n_i), .cd_o(cmd_data_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // External display clock, unrelated to the shift clock
  initial begin
    osc_clock_in_i = 1'b0;
    forever begin
      repeat (3) @(negedge ref_clk_i);
      osc_clock_in_i = ~osc_clock_in_i;
    end
  end
  // Link rate is far below the executor rate, so no word may ever be dropped
  always @(negedge ref_clk_i) begin
    if (rst_i === 1'b0 && overrun_o !== 1'b0) n_overruns++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Executor model: bytes fill two nibbles, address wraps at 5 bits
  task automatic expect_word(input logic [7:0] v, input logic cd);
    if (!cd) begin
      mem[ad] = v[7:4];
      mem[ad + 5'h01] = v[3:0];
      ad = ad + 5'h02;
    end else case (v[7:5])
      3'h0: ad = v[4:0];
      3'h1: md = 2'h1;
      3'h2: md = 2'h0;
      3'h3: md = 2'h2;
      3'h4: begin
        mem[ad] = v[3:0];
        ad = ad + 5'h01;
      end
      3'h6: begin
        ad = 5'h00;
        md = 2'h0;
      end
      default: ;
    endcase
  endtask
  task automatic word(input logic [7:0] v, input logic cd);
    lcd_host_model_inst.send(v, cd, 8, 1'b1);
    expect_word(v, cd);
    chk(32'(address_o), 32'(ad));
    chk(32'(display_mode_o), 32'(md));
  endtask
  function automatic logic [31:0] exp_seg(input int b);
    for (int s = 0; s < 32; s++) exp_seg[s] = (md == 2'h1) || (md == 2'h2 && mem[s][b]);
  endfunction
  // Waits for each common in turn; commons and segments load on one edge,
  // so compare at once, a later look may already be in the next phase
  task automatic check_segs();
    int k;
    for (int b = 0; b < 4; b++) begin
      for (k = 0; k < 200 && common_drive_outputs_o !== (4'h1 << b); k++) @(negedge ref_clk_i);
      if (k == 200) begin
        n_errors++;
        finish_test();
      end
      chk(segment_drive_outputs_o, exp_seg(b));
    end
  endtask
  initial begin
    void'($urandom(32'h33143D57));
    rst_i = 1'b1;
    lcd_reset_n_i = 1'b1;
    osc_ext_sel_i = 1'b0;
    n_errors = 0;
    checks_done = 0;
    ad = 5'h00;
    md = 2'h0;
    foreach (mem[i]) mem[i] = 4'h0;
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
    word(8'hC0, 1'b1);
    $display("test reset_command done");
    // Random mix of address sets, data bytes and nibble rewrites
    repeat (14) begin
      r = $urandom;
      word(r[8] ? (r[9] ? {4'h8, r[3:0]} : {3'h0, r[4:0]}) : r[7:0], r[8]);
    end
    // Byte at the top address wraps the counter to one
    word(8'h1F, 1'b1);
    word(8'hA5, 1'b0);
    word(8'h60, 1'b1);
    check_segs();
    word(8'h20, 1'b1);
    check_segs();
    word(8'h40, 1'b1);
    check_segs();
    $display("test display_modes done");
    // Broken word, then a fresh one after select falls again
    lcd_host_model_inst.send(8'hFF, 1'b1, 3, 1'b1);
    word(8'h05, 1'b1);
    // Undefined opcodes must leave address and mode alone
    word(8'hA0, 1'b1);
    word(8'hE0, 1'b1);
    lcd_host_model_inst.send(8'h0A, 1'b1, 8, 1'b0);
    chk(32'(address_o), 32'(ad));
    $display("test framing done");
    word(8'h60, 1'b1);
    lcd_reset_n_i = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    chk({27'h0, address_o}, 32'h0);
    chk({30'h0, display_mode_o}, 32'h0);
    lcd_reset_n_i = 1'b1;
    ad = 5'h00;
    md = 2'h0;
    repeat (4) @(negedge ref_clk_i);
    word(8'h60, 1'b1);
    osc_ext_sel_i = 1'b1;
    check_segs();
    $display("test pin_reset_ext_clock done");
    chk(32'(n_overruns), 32'h0);
    finish_test();
  end
endmodule
